//--- shared/ppb_pkg.sv
/*
  Shared definitions for the port-block state machines at both ends of the link:
  element codes, state encodings and link field widths.
  Assumes a single core_clk domain shared by both ends and the bench.
*/
package ppb_pkg;

  // one-hot port states, same layout at both ends
  typedef enum logic [3:0] {
    PPB_BLOCKED        = 4'h1,
    PPB_LOCAL_UNBLOCK  = 4'h2,
    PPB_REMOTE_UNBLOCK = 4'h4,
    PPB_OPERATIONAL    = 4'h8
  } ppb_state_t;

  // element codes carried on the link, valid with a one-cycle strobe
  localparam int PPB_ELEM_W = 3;
  typedef enum logic [2:0] {
    PPB_ELEM_NONE                  = 3'h0,
    PPB_EXCHANGE_UNBLOCK_ELEMENT   = 3'h1,
    PPB_ACCESS_UNBLOCK_ELEMENT     = 3'h2,
    PPB_EXCHANGE_BLOCK_ELEMENT     = 3'h3,
    PPB_ACCESS_BLOCK_ELEMENT       = 3'h4,
    PPB_ACCESS_BLOCK_REQUEST_ELEMENT = 3'h5
  } ppb_elem_t;

  localparam ppb_state_t PPB_RESET_STATE = PPB_BLOCKED;

  function automatic logic ppb_is_oper(input ppb_state_t s);
    return s == PPB_OPERATIONAL;
  endfunction

endpackage : ppb_pkg

//--- shared/ppb_link_if.sv
/*
  Link between the access-network port machine and the exchange port machine.
  Each direction is a one-cycle valid strobe with an element code.
  Assumes both ends run on the same clock; no buffering.
*/
interface ppb_link_if;
  import ppb_pkg::*;
  logic to_ex_valid;
  ppb_elem_t to_ex_elem;
  logic to_an_valid;
  ppb_elem_t to_an_elem;

  modport access_network (output to_ex_valid, output to_ex_elem, input to_an_valid, input to_an_elem);
  modport local_exchange (input to_ex_valid, input to_ex_elem, output to_an_valid, output to_an_elem);
endinterface : ppb_link_if

//--- rtl/ppb_access_fsm.sv
/*
  Access-network port-status machine: blocks, requests blocking of and
  co-ordinately unblocks one telephone-line user port.
  Assumes the exchange end keeps its own side of the link protocol and that
  manager primitives are one-cycle pulses on core_clk.
*/
// Behaviour
// R1: only listed elements cross each direction
// R2: four states, three are non-operational
// R3: indicate unblock entering, block leaving operational
// R4: deferrable block request forwarded only operational
// R5: block immediate; unblock, block request acknowledged
// R6: non-operational: call protocol blocked, no lines
// R7: operational: port may originate, terminate calls
// R8: exchange blocks its call protocol non-operationally
// R9: manager block: send block element, go blocked
// R10: exchange block command: send element, go blocked
// R11: operational block request: send element, stay
// R12: exchange forwards block request only operational
// R13: exchange grants request by block command
// R14: manager unblock request withdraws block request
// R15: exchange unblock: send element, local pending
// R16: blocked plus exchange unblock: remote pending
// R17: remote pending plus manager unblock: operational
// R18: local pending plus answer element: operational
// R19: remote pending plus block element: blocked
// R20: no timeout in unblock pending states
// R21: operational unblock request or element: echo
// R22: exchange re-check answered to confirm alignment
// R23: unexpected events ignored, no output
// R24: reset into blocked, nothing pending
module ppb_access_fsm
  import ppb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link
  ppb_link_if.access_network link,
  // manager requests
  input wire logic mgmt_unblock_request,
  input wire logic mgmt_block_command,
  input wire logic mgmt_deferred_block_request,
  // manager indications
  output logic mgmt_unblock_request_ind,
  output logic mgmt_unblock_indication,
  output logic mgmt_block_indication,
  // call-control gating
  output logic call_enable,
  output ppb_state_t port_state
);

  ppb_state_t state_q, state_d;
  logic tx_valid_q, tx_valid_d;
  ppb_elem_t tx_elem_q, tx_elem_d;
  logic ubr_ind_q, ubr_ind_d;
  logic ubi_q, ubi_d;
  logic bi_q, bi_d;
  logic call_en_q;
  logic rx_ex_unblock;
  logic rx_ex_block;

  // one strobe-qualified element match, shared by every inbound decode
  function automatic logic rx_is(input logic valid, input ppb_elem_t elem, input ppb_elem_t want);
    return valid && elem == want;
  endfunction

  // only exchange unblock and block elements are accepted inbound
  assign rx_ex_unblock = rx_is(link.to_an_valid, link.to_an_elem, PPB_EXCHANGE_UNBLOCK_ELEMENT); // R1
  assign rx_ex_block = rx_is(link.to_an_valid, link.to_an_elem, PPB_EXCHANGE_BLOCK_ELEMENT); // R1

  // priority: block command, then received block, then unblocks, then block request;
  // one element is sent per cycle, block wins since it cannot wait for acknowledgement
  // limitation: a lower event in the same cycle is dropped, so the manager must
  // hold off its next primitive until the answer to the last one has come back
  always_comb begin
    state_d = state_q;
    tx_valid_d = 1'b0;
    tx_elem_d = PPB_ELEM_NONE;
    ubr_ind_d = 1'b0;
    ubi_d = 1'b0;
    bi_d = 1'b0;
    if (mgmt_block_command) begin
      // immediate block: sent in every state, never waits for the exchange to agree
      tx_valid_d = 1'b1; // R9
      tx_elem_d = PPB_ACCESS_BLOCK_ELEMENT; // R5
      state_d = PPB_BLOCKED; // R9
      case (state_q)
        PPB_BLOCKED: bi_d = 1'b0;
        PPB_LOCAL_UNBLOCK, PPB_REMOTE_UNBLOCK, PPB_OPERATIONAL: bi_d = 1'b1; // R3
        default: bi_d = 1'b0;
      endcase
    end else if (rx_ex_block) begin
      case (state_q)
        PPB_BLOCKED: begin
          state_d = PPB_BLOCKED;
        end
        PPB_LOCAL_UNBLOCK, PPB_REMOTE_UNBLOCK, PPB_OPERATIONAL: begin
          state_d = PPB_BLOCKED; // R19
          bi_d = 1'b1; // R3
        end
        default: state_d = PPB_BLOCKED;
      endcase
    end else if (mgmt_unblock_request) begin
      tx_valid_d = 1'b1;
      tx_elem_d = PPB_ACCESS_UNBLOCK_ELEMENT;
      case (state_q)
        PPB_BLOCKED: state_d = PPB_LOCAL_UNBLOCK;
        PPB_LOCAL_UNBLOCK: state_d = PPB_LOCAL_UNBLOCK; // R20
        PPB_REMOTE_UNBLOCK: begin
          state_d = PPB_OPERATIONAL; // R17
          ubi_d = 1'b1; // R3
        end
        PPB_OPERATIONAL: begin
          // re-check by the manager; at the exchange it also withdraws a block request
          state_d = PPB_OPERATIONAL; // R21
          ubi_d = 1'b1; // R21 R14
        end
        default: state_d = PPB_BLOCKED;
      endcase
    end else if (rx_ex_unblock) begin
      case (state_q)
        PPB_BLOCKED: begin
          state_d = PPB_REMOTE_UNBLOCK; // R16
          ubr_ind_d = 1'b1; // R16
        end
        PPB_LOCAL_UNBLOCK: begin
          state_d = PPB_OPERATIONAL; // R18
          ubi_d = 1'b1; // R3
        end
        // repeated request from the exchange: forward again and keep waiting, no timer
        PPB_REMOTE_UNBLOCK: ubr_ind_d = 1'b1; // R20
        PPB_OPERATIONAL: begin
          tx_valid_d = 1'b1; // R21 R22
          tx_elem_d = PPB_ACCESS_UNBLOCK_ELEMENT;
          ubi_d = 1'b1;
        end
        default: state_d = PPB_BLOCKED;
      endcase
    end else if (mgmt_deferred_block_request) begin
      // only meaningful while calls can run; the exchange grants it later by blocking
      case (state_q)
        PPB_OPERATIONAL: begin
          tx_valid_d = 1'b1; // R4 R11
          tx_elem_d = PPB_ACCESS_BLOCK_REQUEST_ELEMENT; // R11
        end
        PPB_BLOCKED: state_d = PPB_BLOCKED;
        // unexpected while an unblock handshake is open: no element, no state change
        PPB_LOCAL_UNBLOCK, PPB_REMOTE_UNBLOCK: state_d = state_q; // R23
        default: state_d = PPB_BLOCKED;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= PPB_RESET_STATE; // R24
    end else begin
      state_q <= state_d; // R2
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid_q <= 1'b0; // R24
      tx_elem_q <= PPB_ELEM_NONE;
    end else begin
      tx_valid_q <= tx_valid_d;
      tx_elem_q <= tx_elem_d;
    end
  end

  // request forwarded from the exchange
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ubr_ind_q <= 1'b0; // R24
    end else begin
      ubr_ind_q <= ubr_ind_d; // R16
    end
  end

  // notifications of entering and leaving operational
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ubi_q <= 1'b0; // R24
      bi_q <= 1'b0;
    end else begin
      ubi_q <= ubi_d; // R3
      bi_q <= bi_d; // R3
    end
  end

  // call gating is registered from the next state (state_d) so it changes with the indications
  // a port is thus never opened to calls ahead of the unblock indication
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      call_en_q <= 1'b0; // R6
    end else begin
      call_en_q <= ppb_is_oper(state_d); // R6 R7
    end
  end

  assign link.to_ex_valid = tx_valid_q;
  assign link.to_ex_elem = tx_elem_q;
  assign mgmt_unblock_request_ind = ubr_ind_q;
  assign mgmt_unblock_indication = ubi_q;
  assign mgmt_block_indication = bi_q;
  assign call_enable = call_en_q;
  assign port_state = state_q;

endmodule // ppb_access_fsm

//--- rtl/ppb_exchange_fsm.sv
/*
  Exchange port-status machine, the far end of the access-network machine.
  Assumes manager primitives are one-cycle pulses on core_clk and the access
  end sends only its own three elements.
*/
module ppb_exchange_fsm
  import ppb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link
  ppb_link_if.local_exchange link,
  // manager requests
  input wire logic mgmt_unblock_request,
  input wire logic mgmt_block_command,
  // manager indications
  output logic mgmt_unblock_request_ind,
  output logic mgmt_unblock_indication,
  output logic mgmt_block_indication,
  output logic mgmt_deferred_block_request,
  // call-control gating
  output logic call_enable,
  output ppb_state_t port_state
);

  ppb_state_t state_q, state_d;
  logic tx_valid_q, tx_valid_d;
  ppb_elem_t tx_elem_q, tx_elem_d;
  logic ubr_q, ubr_d, ubi_q, ubi_d, bi_q, bi_d, br_q, br_d;
  logic call_en_q;
  logic rx_unb, rx_blk, rx_breq;

  // one strobe-qualified element match, shared by every inbound decode
  function automatic logic rx_is(input logic valid, input ppb_elem_t elem, input ppb_elem_t want);
    return valid && elem == want;
  endfunction

  assign rx_unb = rx_is(link.to_ex_valid, link.to_ex_elem, PPB_ACCESS_UNBLOCK_ELEMENT); // R1
  assign rx_blk = rx_is(link.to_ex_valid, link.to_ex_elem, PPB_ACCESS_BLOCK_ELEMENT); // R1
  assign rx_breq = rx_is(link.to_ex_valid, link.to_ex_elem, PPB_ACCESS_BLOCK_REQUEST_ELEMENT); // R1

  always_comb begin
    state_d = state_q;
    tx_valid_d = 1'b0;
    tx_elem_d = PPB_ELEM_NONE;
    ubr_d = 1'b0;
    ubi_d = 1'b0;
    bi_d = 1'b0;
    br_d = 1'b0;
    if (mgmt_block_command) begin
      tx_valid_d = 1'b1; // R10 R13
      tx_elem_d = PPB_EXCHANGE_BLOCK_ELEMENT;
      state_d = PPB_BLOCKED; // R10
      bi_d = state_q != PPB_BLOCKED; // R3
    end else if (rx_blk) begin
      if (state_q != PPB_BLOCKED) begin
        state_d = PPB_BLOCKED; // R19
        bi_d = 1'b1; // R3
      end
    end else if (mgmt_unblock_request) begin
      tx_valid_d = 1'b1; // R15 R22
      tx_elem_d = PPB_EXCHANGE_UNBLOCK_ELEMENT;
      case (state_q)
        PPB_BLOCKED: state_d = PPB_LOCAL_UNBLOCK; // R15
        PPB_LOCAL_UNBLOCK: state_d = PPB_LOCAL_UNBLOCK; // R20
        PPB_REMOTE_UNBLOCK: begin
          state_d = PPB_OPERATIONAL;
          ubi_d = 1'b1; // R3
        end
        PPB_OPERATIONAL: state_d = PPB_OPERATIONAL; // R22
        default: state_d = PPB_BLOCKED;
      endcase
    end else if (rx_unb) begin
      case (state_q)
        PPB_BLOCKED: begin
          state_d = PPB_REMOTE_UNBLOCK;
          ubr_d = 1'b1;
        end
        PPB_LOCAL_UNBLOCK: begin
          state_d = PPB_OPERATIONAL; // R18
          ubi_d = 1'b1; // R3
        end
        PPB_REMOTE_UNBLOCK: ubr_d = 1'b1; // R20
        PPB_OPERATIONAL: ubi_d = 1'b1; // R14 R22
        default: state_d = PPB_BLOCKED;
      endcase
    end else if (rx_breq) begin
      br_d = ppb_is_oper(state_q); // R12 R23
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= PPB_RESET_STATE; // R24
    end else begin
      state_q <= state_d; // R2
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_elem_q <= PPB_ELEM_NONE;
      ubr_q <= 1'b0;
      ubi_q <= 1'b0;
      bi_q <= 1'b0;
      br_q <= 1'b0;
    end else begin
      tx_valid_q <= tx_valid_d;
      tx_elem_q <= tx_elem_d;
      ubr_q <= ubr_d;
      ubi_q <= ubi_d;
      bi_q <= bi_d;
      br_q <= br_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      call_en_q <= 1'b0;
    end else begin
      call_en_q <= ppb_is_oper(state_d); // R8
    end
  end

  assign link.to_an_valid = tx_valid_q;
  assign link.to_an_elem = tx_elem_q;
  assign mgmt_unblock_request_ind = ubr_q;
  assign mgmt_unblock_indication = ubi_q;
  assign mgmt_block_indication = bi_q;
  assign mgmt_deferred_block_request = br_q;
  assign call_enable = call_en_q;
  assign port_state = state_q;

endmodule // ppb_exchange_fsm

//--- bench/ppb_link_monitor.sv
/*
  Link checker for the two port-block machines: watches both strobe directions.
  Assumes one core_clk shared by both ends; instantiated beside the link.
*/
module ppb_link_monitor
  import ppb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link
  input wire logic to_ex_valid,
  input wire ppb_elem_t to_ex_elem,
  input wire logic to_an_valid,
  input wire ppb_elem_t to_an_elem
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ex_elem_legal_a: assert property (to_ex_valid |-> to_ex_elem inside {PPB_ACCESS_UNBLOCK_ELEMENT,
    PPB_ACCESS_BLOCK_ELEMENT, PPB_ACCESS_BLOCK_REQUEST_ELEMENT}) else $error("bad element toward exchange");
  an_elem_legal_a: assert property (to_an_valid |-> to_an_elem inside {PPB_EXCHANGE_UNBLOCK_ELEMENT,
    PPB_EXCHANGE_BLOCK_ELEMENT}) else $error("bad element toward access end");
  ex_idle_none_a: assert property (!to_ex_valid |-> to_ex_elem == PPB_ELEM_NONE)
    else $error("element code without strobe toward exchange");
  an_idle_none_a: assert property (!to_an_valid |-> to_an_elem == PPB_ELEM_NONE)
    else $error("element code without strobe toward access end");
  // block element outranks a same-cycle unblock or block request, so neither may follow
  block_no_unblock_a: assert property ((to_an_valid && to_an_elem == PPB_EXCHANGE_BLOCK_ELEMENT) |=>
    !(to_ex_valid && to_ex_elem inside {PPB_ACCESS_UNBLOCK_ELEMENT, PPB_ACCESS_BLOCK_REQUEST_ELEMENT}))
    else $error("access end answered a block element");
  block_no_echo_a: assert property ((to_ex_valid && to_ex_elem == PPB_ACCESS_BLOCK_ELEMENT) |=>
    !(to_an_valid && to_an_elem == PPB_EXCHANGE_UNBLOCK_ELEMENT)) else $error("exchange unblocked on block");
  reset_quiet_a: assert property (disable iff (1'b0) rst |-> !to_ex_valid && !to_an_valid)
    else $error("strobe during reset");
  reset_release_a: assert property (disable iff (1'b0) $fell(rst) |->
    to_ex_elem == PPB_ELEM_NONE && to_an_elem == PPB_ELEM_NONE) else $error("element pending after reset");

  cover property (to_ex_valid && to_ex_elem == PPB_ACCESS_BLOCK_REQUEST_ELEMENT);
  cover property (to_an_valid && to_an_elem == PPB_EXCHANGE_UNBLOCK_ELEMENT);
  cover property (to_ex_valid && to_ex_elem == PPB_ACCESS_BLOCK_ELEMENT);
endmodule // ppb_link_monitor

//--- bench/pstn_port_block_fsm_tb.sv
/*
  Bench joining the access and exchange port machines over one link.
  Assumes one-cycle answers; inputs change on the falling edge of core_clk.
*/
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pstn_port_block_fsm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppb_pkg::*;
  logic core_clk = 1'b0;
  // raised by a non-blocking write at time zero so the asynchronous reset sees an edge
  logic rst = 1'b0;
  logic a_ubr = 1'b0, a_bc = 1'b0, a_dbr = 1'b0, e_ubr = 1'b0, e_bc = 1'b0;
  logic a_ubri, a_ubi, a_bi, a_ce, e_ubri, e_ubi, e_bi, e_dbr, e_ce;
  ppb_state_t a_st, e_st;
  int errors = 0, cmp_count = 0, cycles = 0;
  ppb_link_if link();
  ppb_access_fsm ppb_access_fsm_inst (.core_clk(core_clk), .rst(rst), .link(link), .mgmt_unblock_request(a_ubr),
    .mgmt_block_command(a_bc), .mgmt_deferred_block_request(a_dbr), .mgmt_unblock_request_ind(a_ubri),
    .mgmt_unblock_indication(a_ubi), .mgmt_block_indication(a_bi), .call_enable(a_ce), .port_state(a_st));
  ppb_exchange_fsm ppb_exchange_fsm_inst (.core_clk(core_clk), .rst(rst), .link(link), .mgmt_unblock_request(e_ubr),
    .mgmt_block_command(e_bc), .mgmt_unblock_request_ind(e_ubri), .mgmt_unblock_indication(e_ubi),
    .mgmt_block_indication(e_bi), .mgmt_deferred_block_request(e_dbr), .call_enable(e_ce), .port_state(e_st));
  ppb_link_monitor ppb_link_monitor_inst (.core_clk(core_clk), .rst(rst), .to_ex_valid(link.to_ex_valid),
    .to_ex_elem(link.to_ex_elem), .to_an_valid(link.to_an_valid), .to_an_elem(link.to_an_elem));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ceiling well above the roughly eighty cycles the tests take
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      complete_run();
    end
  end

  task automatic tick();
    @(negedge core_clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic t_reset();
    `CHK(a_st, PPB_BLOCKED)
    `CHK(e_st, PPB_BLOCKED)
    `CHK(a_ce, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_ex_unblock();
    e_ubr = 1'b1; tick(); e_ubr = 1'b0;
    `CHK(link.to_an_elem, PPB_EXCHANGE_UNBLOCK_ELEMENT)
    `CHK(e_st, PPB_LOCAL_UNBLOCK)
    tick();
    `CHK(a_st, PPB_REMOTE_UNBLOCK)
    `CHK(a_ubri, 1'b1)
    a_ubr = 1'b1; tick(); a_ubr = 1'b0;
    `CHK(link.to_ex_elem, PPB_ACCESS_UNBLOCK_ELEMENT)
    `CHK(a_st, PPB_OPERATIONAL)
    `CHK(a_ubi, 1'b1)
    `CHK(a_ce, 1'b1)
    tick();
    `CHK(e_st, PPB_OPERATIONAL)
    `CHK(e_ubi, 1'b1)
    $display("test exchange unblock done");
  endtask

  task automatic t_block_request();
    a_dbr = 1'b1; tick(); a_dbr = 1'b0;
    `CHK(link.to_ex_elem, PPB_ACCESS_BLOCK_REQUEST_ELEMENT)
    `CHK(a_st, PPB_OPERATIONAL)
    tick();
    `CHK(e_dbr, 1'b1)
    e_bc = 1'b1; tick(); e_bc = 1'b0;
    `CHK(link.to_an_elem, PPB_EXCHANGE_BLOCK_ELEMENT)
    `CHK(e_st, PPB_BLOCKED)
    `CHK(e_ce, 1'b0)
    `CHK(e_bi, 1'b1)
    tick();
    `CHK(a_st, PPB_BLOCKED)
    `CHK(a_bi, 1'b1)
    `CHK(a_ce, 1'b0)
    a_dbr = 1'b1; tick(); a_dbr = 1'b0;
    `CHK(link.to_ex_valid, 1'b0)
    $display("test block request done");
  endtask

  task automatic t_an_unblock();
    a_ubr = 1'b1; tick(); a_ubr = 1'b0;
    `CHK(link.to_ex_elem, PPB_ACCESS_UNBLOCK_ELEMENT)
    `CHK(a_st, PPB_LOCAL_UNBLOCK)
    a_dbr = 1'b1; tick(); a_dbr = 1'b0;
    `CHK(e_st, PPB_REMOTE_UNBLOCK)
    `CHK(e_ubri, 1'b1)
    `CHK(link.to_ex_valid, 1'b0)
    `CHK(a_st, PPB_LOCAL_UNBLOCK)
    e_ubr = 1'b1; tick(); e_ubr = 1'b0;
    `CHK(link.to_an_elem, PPB_EXCHANGE_UNBLOCK_ELEMENT)
    `CHK(e_st, PPB_OPERATIONAL)
    `CHK(e_ubi, 1'b1)
    tick();
    `CHK(a_st, PPB_OPERATIONAL)
    `CHK(a_ubi, 1'b1)
    $display("test access unblock done");
  endtask

  task automatic t_recheck();
    a_ubr = 1'b1; tick(); a_ubr = 1'b0;
    `CHK(a_ubi, 1'b1)
    `CHK(link.to_ex_elem, PPB_ACCESS_UNBLOCK_ELEMENT)
    tick();
    `CHK(link.to_an_valid, 1'b0)
    e_ubr = 1'b1; tick(); e_ubr = 1'b0;
    `CHK(link.to_an_elem, PPB_EXCHANGE_UNBLOCK_ELEMENT)
    `CHK(e_st, PPB_OPERATIONAL)
    tick();
    `CHK(link.to_ex_elem, PPB_ACCESS_UNBLOCK_ELEMENT)
    `CHK(a_ubi, 1'b1)
    tick();
    `CHK(e_ubi, 1'b1)
    $display("test recheck done");
  endtask

  task automatic t_remote_cancel();
    a_bc = 1'b1; tick(); a_bc = 1'b0;
    `CHK(link.to_ex_elem, PPB_ACCESS_BLOCK_ELEMENT)
    `CHK(a_st, PPB_BLOCKED)
    `CHK(a_bi, 1'b1)
    tick();
    `CHK(e_st, PPB_BLOCKED)
    `CHK(e_bi, 1'b1)
    a_bc = 1'b1; tick(); a_bc = 1'b0;
    `CHK(link.to_ex_elem, PPB_ACCESS_BLOCK_ELEMENT)
    `CHK(a_bi, 1'b0)
    // let the repeated block element land first: it outranks a same-cycle unblock request
    tick();
    e_ubr = 1'b1; tick(); e_ubr = 1'b0;
    tick();
    `CHK(a_st, PPB_REMOTE_UNBLOCK)
    repeat (50) tick();
    `CHK(a_st, PPB_REMOTE_UNBLOCK)
    `CHK(e_st, PPB_LOCAL_UNBLOCK)
    e_bc = 1'b1; tick(); e_bc = 1'b0;
    tick();
    `CHK(a_st, PPB_BLOCKED)
    `CHK(a_bi, 1'b1)
    $display("test remote cancel done");
  endtask

  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    tick();
    rst = 1'b0;
    t_reset();
    t_ex_unblock();
    t_block_request();
    t_an_unblock();
    t_recheck();
    t_remote_cancel();
    complete_run();
  end
endmodule // pstn_port_block_fsm_tb
